/* design/cluster_pkg.sv */
// Shared constants, types and register map of the logic cluster.
// Assumes a single 50 MHz APB clock domain.
`default_nettype none

package cluster_pkg;

  // Cluster geometry
  localparam int CELLS = 10;
  localparam int CARRY_GEN_LOW = 4;
  localparam int CARRY_GEN_HIGH = 10;
  localparam int MUL_WIDTH = 16;
  localparam int PROD_WIDTH = 32;
  localparam int PAIRS = 8;

  // APB byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPERANDS = 8'h04;
  localparam logic [7:0] OFS_ASYNC = 8'h08;
  localparam logic [7:0] OFS_SUM = 8'h0c;
  localparam logic [7:0] OFS_MUL_OPS = 8'h10;
  localparam logic [7:0] OFS_PRODUCT = 8'h14;

  // Control word field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_LSB = 2;
  localparam int CTRL_CARRY_IN = 6;
  localparam int CTRL_FROM_LINK = 7;
  localparam int CTRL_BYPASS = 8;
  localparam int CTRL_CE_FIRST = 9;
  localparam int CTRL_CHIP_CLR_EN = 10;
  localparam int CTRL_FAST_ROUTE = 11;
  localparam int CTRL_SIGNED = 12;
  localparam int CTRL_PIPELINED = 13;

  // Other field positions
  localparam int OPB_LSB = 16;
  localparam int ASYNC_CLEAR = 0;
  localparam int ASYNC_PRESET = 1;
  localparam int SUM_CARRY_BIT = 16;
  localparam int SUM_SEG_CARRY_BIT = 17;
  localparam int MUL_B_LSB = 16;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ARITH = 2'b01,
    MODE_MULT = 2'b10
  } cell_mode_e;

  typedef struct packed {
    logic pipelined;
    logic mult_signed;
    logic fast_route;
    logic chip_clear_enable;
    logic clock_enable_first;
    logic bypass;
    logic from_link;
    logic carry_in;
    logic [3:0] chain_start;
    cell_mode_e mode;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{default: '0, mode: MODE_NORMAL};

  // Speculative carry pair plus the chain select that goes with it
  typedef struct packed {
    logic carry_assume_zero;
    logic carry_assume_one;
    logic select;
  } carry_link_s;

  typedef struct packed {
    logic sum_reg;
  } cell_state_s;

  typedef struct packed {
    logic [1:0] clr_sync;
    ctrl_s ctrl;
    logic [CELLS-1:0] op_a;
    logic [CELLS-1:0] op_b;
    logic shared_clear;
    logic shared_preset;
    logic [MUL_WIDTH-1:0] mul_a;
    logic [MUL_WIDTH-1:0] mul_b;
    logic [PAIRS-1:0][PROD_WIDTH-1:0] pairs;
    logic [PROD_WIDTH-1:0] product;
    logic [31:0] rdata;
    logic slverr;
  } cluster_state_s;

endpackage : cluster_pkg

`default_nettype wire

/* design/logic_cell.sv */
// One logic cell: carry-select sum/carry pair and its register.
// Assumes async controls come from cluster logic on the same clock.
`default_nettype none

module logic_cell
  import cluster_pkg::*;
(
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cell_clear,
  input wire logic cell_preset,
  // Register control
  input wire logic clock_enable,
  input wire logic register_bypass,
  // Operands
  input wire logic op_a,
  input wire logic op_b,
  // Carry chain
  input wire logic carry_assume_zero_in,
  input wire logic carry_assume_one_in,
  input wire logic chain_restart,
  input wire logic chain_select,
  // Results
  output logic cell_out,
  output logic carry_assume_zero_out,
  output logic carry_assume_one_out,
  output logic real_carry
);

  cell_state_s state;
  cell_state_s next_state;
  logic c0;
  logic c1;
  logic prop;
  logic gen;
  logic sum_value;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    c0 = chain_restart ? 1'b0 : carry_assume_zero_in;
    c1 = chain_restart ? 1'b1 : carry_assume_one_in;
    prop = op_a ^ op_b;
    gen = op_a & op_b;
    // Both assumptions worked out side by side
    carry_assume_zero_out = gen | (prop & c0);
    carry_assume_one_out = gen | (prop & c1);
    real_carry = chain_select ? c1 : c0;
    sum_value = prop ^ real_carry;
    next_state = state;
    if (clock_enable) begin
      next_state.sum_reg = sum_value;
    end
    cell_out = register_bypass ? sum_value : state.sum_reg;
  end

  // Clear tested before preset so it wins
  always_ff @(posedge pclk or negedge presetn or posedge cell_clear
              or posedge cell_preset) begin
    if (!presetn) begin
      state <= '0;
    end else if (cell_clear) begin
      state <= '0;
    end else if (cell_preset) begin
      state <= '1;
    end else begin
      state <= next_state;
    end
  end

endmodule : logic_cell

`default_nettype wire

/* design/logic_cluster.sv */
// Logic cluster: ten carry-select cells, carry cell, 16x16 tree multiplier.
// Assumes an APB master on pclk; neighbour clusters share pclk.
`default_nettype none

module logic_cluster
  import cluster_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip-wide clear pin
  input wire logic chip_wide_register_clear_n,
  // Row chain from and to clusters two positions away
  input wire carry_link_s row_link_in,
  output carry_link_s row_link_out,
  // Column chain for multiplier mode
  input wire carry_link_s column_link_in,
  output carry_link_s column_link_out,
  // Routing outputs
  output logic [CELLS-1:0] local_routing_out,
  output logic [CELLS-1:0] fast_horizontal_routing_out,
  output logic carry_routing_out
);

  cluster_state_s state;
  cluster_state_s next_state;

  logic [CELLS:0] c0;
  logic [CELLS:0] c1;
  logic [CELLS-1:0] restart;
  logic [CELLS-1:0] select;
  logic [CELLS-1:0] real_carry;
  logic [CELLS-1:0] cell_out;
  logic [CELLS-1:0] cell_a;
  logic [CELLS-1:0] cell_b;
  logic seg_low_select;
  logic seg_high_select;
  logic final_carry;
  logic carry_cell_out;
  logic cell_clear;
  logic cell_preset;
  logic cell_enable;
  logic mult_mode;
  logic link_start;
  carry_link_s link_in;
  logic setup;
  logic access;

  //////////////////////////////////////////////////////////////////////////
  // Multiplier tree

  // Partial products and first pair sum share one level of logic
  function automatic logic [PAIRS-1:0][PROD_WIDTH-1:0] pair_stage(
    input logic [MUL_WIDTH-1:0] a,
    input logic [MUL_WIDTH-1:0] b,
    input logic sgn
  );
    logic [PROD_WIDTH-1:0] ext;
    logic [MUL_WIDTH-1:0][PROD_WIDTH-1:0] pp;
    logic [PAIRS-1:0][PROD_WIDTH-1:0] res;
    ext = sgn ? {{MUL_WIDTH{a[MUL_WIDTH-1]}}, a} : {{MUL_WIDTH{1'b0}}, a};
    for (int i = 0; i < MUL_WIDTH; i++) begin
      pp[i] = b[i] ? (ext << i) : '0;
    end
    // Top multiplier bit carries negative weight when signed
    if (sgn) begin
      pp[MUL_WIDTH-1] = PROD_WIDTH'(-pp[MUL_WIDTH-1]);
    end
    for (int k = 0; k < PAIRS; k++) begin
      res[k] = PROD_WIDTH'(pp[2*k] + pp[2*k+1]);
    end
    return res;
  endfunction : pair_stage

  // Remaining three pairwise levels of the tree
  function automatic logic [PROD_WIDTH-1:0] reduce_tree(
    input logic [PAIRS-1:0][PROD_WIDTH-1:0] p
  );
    logic [3:0][PROD_WIDTH-1:0] l3;
    logic [1:0][PROD_WIDTH-1:0] l4;
    for (int k = 0; k < 4; k++) begin
      l3[k] = PROD_WIDTH'(p[2*k] + p[2*k+1]);
    end
    for (int k = 0; k < 2; k++) begin
      l4[k] = PROD_WIDTH'(l3[2*k] + l3[2*k+1]);
    end
    return PROD_WIDTH'(l4[0] + l4[1]);
  endfunction : reduce_tree

  //////////////////////////////////////////////////////////////////////////
  // Chain control

  always_comb begin
    mult_mode = (state.ctrl.mode == MODE_MULT);
    // Dedicated multipliers chain along the column instead of the row
    link_in = mult_mode ? column_link_in : row_link_in;
    link_start = state.ctrl.from_link && (state.ctrl.chain_start == 4'h0);
    for (int i = 0; i < CELLS; i++) begin
      restart[i] = (4'(i) == state.ctrl.chain_start) && !link_start;
    end
    // Chain crossing the cell-4 boundary restarts there
    if (state.ctrl.chain_start < 4'(CARRY_GEN_LOW)) begin
      restart[CARRY_GEN_LOW] = 1'b1;
    end
    seg_low_select = link_start ? link_in.select : state.ctrl.carry_in;
    // Carry out of cell 3 (not its carry in) starts the upper segment
    if (state.ctrl.chain_start < 4'(CARRY_GEN_LOW)) begin
      seg_high_select = seg_low_select ? c1[CARRY_GEN_LOW]
                                       : c0[CARRY_GEN_LOW];
    end else begin
      seg_high_select = state.ctrl.carry_in;
    end
    for (int i = 0; i < CELLS; i++) begin
      select[i] = (i < CARRY_GEN_LOW) ? seg_low_select : seg_high_select;
    end
    // Chosen chain's carry out of the last cell, not its carry in
    final_carry = select[CELLS-1] ? c1[CARRY_GEN_HIGH]
                                  : c0[CARRY_GEN_HIGH];
  end

  assign c0[0] = link_in.carry_assume_zero;
  assign c1[0] = link_in.carry_assume_one;

  //////////////////////////////////////////////////////////////////////////
  // Cell operands and shared controls

  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      if (mult_mode) begin
        // Crossed products of adjacent bits
        cell_a[i] = state.mul_a[i] & state.mul_b[1];
        cell_b[i] = state.mul_a[i+1] & state.mul_b[0];
      end else begin
        cell_a[i] = state.op_a[i];
        cell_b[i] = state.op_b[i];
      end
    end
    // Chip clear is just one more clear term, so it beats preset too
    cell_clear = state.shared_clear
      || (state.ctrl.chip_clear_enable && !state.clr_sync[1]);
    // In multiplier mode the preset resource steers the product instead
    cell_preset = state.shared_preset && !mult_mode;
    // First enable is taken by the product logic in multiplier mode
    cell_enable = mult_mode ? 1'b1 : state.ctrl.clock_enable_first;
  end

  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .cell_clear(cell_clear),
      .cell_preset(cell_preset),
      .clock_enable(cell_enable),
      .register_bypass(state.ctrl.bypass),
      .op_a(cell_a[i]),
      .op_b(cell_b[i]),
      .carry_assume_zero_in(c0[i]),
      .carry_assume_one_in(c1[i]),
      .chain_restart(restart[i]),
      .chain_select(select[i]),
      .cell_out(cell_out[i]),
      .carry_assume_zero_out(c0[i+1]),
      .carry_assume_one_out(c1[i+1]),
      .real_carry(real_carry[i])
    );
  end

  // Final carry passes through a cell of its own to reach routing
  logic_cell u_carry_cell (
    .pclk(pclk),
    .presetn(presetn),
    .cell_clear(cell_clear),
    .cell_preset(cell_preset),
    .clock_enable(cell_enable),
    .register_bypass(state.ctrl.bypass),
    .op_a(final_carry),
    .op_b(1'b0),
    .carry_assume_zero_in(1'b0),
    .carry_assume_one_in(1'b0),
    .chain_restart(1'b0),
    .chain_select(1'b0),
    .cell_out(carry_cell_out),
    .carry_assume_zero_out(),
    .carry_assume_one_out(),
    .real_carry()
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    row_link_out = '0;
    column_link_out = '0;
    if (mult_mode) begin
      column_link_out.carry_assume_zero = c0[CELLS];
      column_link_out.carry_assume_one = c1[CELLS];
      column_link_out.select = seg_high_select;
    end else begin
      row_link_out.carry_assume_zero = c0[CELLS];
      row_link_out.carry_assume_one = c1[CELLS];
      row_link_out.select = seg_high_select;
    end
    if (state.ctrl.fast_route) begin
      fast_horizontal_routing_out = cell_out;
      local_routing_out = '0;
    end else begin
      fast_horizontal_routing_out = '0;
      local_routing_out = cell_out;
    end
    carry_routing_out = carry_cell_out;
  end

  //////////////////////////////////////////////////////////////////////////
  // APB slave and state update

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = state.rdata;
  assign pslverr = state.slverr && access;

  always_comb begin
    next_state = state;
    // Pin crosses two flops before anything reads it
    next_state.clr_sync = {state.clr_sync[0], chip_wide_register_clear_n};

    // Product stage only advances on the first clock enable
    if (mult_mode && state.ctrl.clock_enable_first) begin
      next_state.pairs = pair_stage(state.mul_a, state.mul_b,
                                    state.ctrl.mult_signed);
      if (state.shared_preset) begin
        next_state.product = '0;
      end else if (state.ctrl.pipelined) begin
        next_state.product = reduce_tree(state.pairs);
      end else begin
        next_state.product = reduce_tree(next_state.pairs);
      end
    end

    // Read data and error are latched in setup, shown in access
    if (setup) begin
      next_state.rdata = '0;
      next_state.slverr = 1'b0;
      unique case (paddr)
        OFS_CTRL: next_state.rdata[13:0] = state.ctrl;
        OFS_OPERANDS: begin
          next_state.rdata[CELLS-1:0] = state.op_a;
          next_state.rdata[OPB_LSB +: CELLS] = state.op_b;
        end
        OFS_ASYNC: begin
          next_state.rdata[ASYNC_CLEAR] = state.shared_clear;
          next_state.rdata[ASYNC_PRESET] = state.shared_preset;
        end
        OFS_SUM: begin
          next_state.rdata[CELLS-1:0] = cell_out;
          next_state.rdata[SUM_CARRY_BIT] = carry_cell_out;
          next_state.rdata[SUM_SEG_CARRY_BIT] = seg_high_select;
        end
        OFS_MUL_OPS: begin
          next_state.rdata[MUL_WIDTH-1:0] = state.mul_a;
          next_state.rdata[MUL_B_LSB +: MUL_WIDTH] = state.mul_b;
        end
        OFS_PRODUCT: next_state.rdata = state.product;
        default: next_state.slverr = 1'b1;
      endcase
    end

    // Writes land at the access edge
    if (access && pwrite) begin
      unique case (paddr)
        OFS_CTRL: begin
          next_state.ctrl.mode = cell_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
          next_state.ctrl.chain_start = pwdata[CTRL_START_LSB +: 4];
          next_state.ctrl.carry_in = pwdata[CTRL_CARRY_IN];
          next_state.ctrl.from_link = pwdata[CTRL_FROM_LINK];
          next_state.ctrl.bypass = pwdata[CTRL_BYPASS];
          next_state.ctrl.clock_enable_first = pwdata[CTRL_CE_FIRST];
          next_state.ctrl.chip_clear_enable = pwdata[CTRL_CHIP_CLR_EN];
          next_state.ctrl.fast_route = pwdata[CTRL_FAST_ROUTE];
          next_state.ctrl.mult_signed = pwdata[CTRL_SIGNED];
          next_state.ctrl.pipelined = pwdata[CTRL_PIPELINED];
        end
        OFS_OPERANDS: begin
          next_state.op_a = pwdata[CELLS-1:0];
          next_state.op_b = pwdata[OPB_LSB +: CELLS];
        end
        OFS_ASYNC: begin
          next_state.shared_clear = pwdata[ASYNC_CLEAR];
          next_state.shared_preset = pwdata[ASYNC_PRESET];
        end
        OFS_MUL_OPS: begin
          next_state.mul_a = pwdata[MUL_WIDTH-1:0];
          next_state.mul_b = pwdata[MUL_B_LSB +: MUL_WIDTH];
        end
        default: begin
        end
      endcase
    end
  end

  // Sync flops reset high so a reset does not look like a chip clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{clr_sync: 2'b11, ctrl: CTRL_RESET, default: '0};
    end else begin
      state <= next_state;
    end
  end

endmodule : logic_cluster

`default_nettype wire

/* tb/logic_cluster_sva.sv */
// Checker: port-level properties of the logic cluster.
// Assumes it is bound onto logic_cluster and sees only its ports.
`default_nettype none

module logic_cluster_sva
  import cluster_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fabric outputs
  input wire carry_link_s row_link_out,
  input wire carry_link_s column_link_out,
  input wire logic [CELLS-1:0] local_routing_out,
  input wire logic [CELLS-1:0] fast_horizontal_routing_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  AST_ERR_UNMAPPED: assert property (psel && !penable && paddr > OFS_PRODUCT
    ##1 psel && penable |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_NO_ERR_MAPPED: assert property (psel && !penable
    && paddr <= OFS_PRODUCT && paddr[1:0] == 2'b00
    ##1 psel && penable |-> !pslverr)
    else $error("mapped access refused");
  AST_RDATA_HOLD: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved after access");
  AST_AFTER_RESET: assert property ($rose(presetn)
    |-> prdata == 32'h0 && !pslverr && local_routing_out == '0)
    else $error("outputs not quiet after reset");
  AST_FAST_EXCL: assert property (
    !(|local_routing_out && |fast_horizontal_routing_out))
    else $error("local and fast routing both driven");
  AST_LINK_EXCL: assert property (
    !(|row_link_out && |column_link_out))
    else $error("row and column chains both driven");
endmodule : logic_cluster_sva

bind logic_cluster logic_cluster_sva chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .row_link_out(row_link_out),
  .column_link_out(column_link_out), .local_routing_out(local_routing_out),
  .fast_horizontal_routing_out(fast_horizontal_routing_out));

`default_nettype wire

/* tb/neighbour_cluster.sv */
// Model of a neighbouring cluster on a carry link.
// Assumes the link is combinational, same clock domain, no handshake.
`default_nettype none

module neighbour_cluster
  import cluster_pkg::*;
(
  // Control from the bench
  input wire logic real_carry,
  input wire logic chain_pick,
  // Link facing the cluster
  input wire carry_link_s from_cluster,
  output var carry_link_s to_cluster,
  output logic out_carry
);
  // Unchosen chain holds the inverse, so a wrong pick shows
  always_comb begin
    to_cluster.select = chain_pick;
    to_cluster.carry_assume_one = chain_pick ? real_carry : !real_carry;
    to_cluster.carry_assume_zero = chain_pick ? !real_carry : real_carry;
  end
  // Real carry of the chain the far cluster picked
  assign out_carry = from_cluster.select ? from_cluster.carry_assume_one
    : from_cluster.carry_assume_zero;
endmodule : neighbour_cluster

`default_nettype wire

/* tb/carry_select_logic_cell_array_test.sv */
// Self-checking bench for the logic cluster over APB.
// Assumes the cluster package and the neighbour model are compiled first.
`default_nettype none

module carry_select_logic_cell_array_test
  import cluster_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clr_n = 1'b1;
  logic rc = 1'b0;
  logic pick = 1'b0;
  logic out_carry;
  carry_link_s row_in, row_out, col_in, col_out;
  logic [CELLS-1:0] loc, fast;
  logic carry_out;
  logic [31:0] rd;
  logic err;
  ctrl_s c;
  int err_total = 0;
  int checks = 0;

  always #10 pclk = ~pclk;

  logic_cluster dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_wide_register_clear_n(clr_n), .row_link_in(row_in),
    .row_link_out(row_out), .column_link_in(col_in),
    .column_link_out(col_out), .local_routing_out(loc),
    .fast_horizontal_routing_out(fast), .carry_routing_out(carry_out));
  neighbour_cluster row_nb (.real_carry(rc), .chain_pick(pick),
    .from_cluster(row_out), .to_cluster(row_in), .out_carry(out_carry));
  neighbour_cluster col_nb (.real_carry(rc), .chain_pick(pick),
    .from_cluster(col_out), .to_cluster(col_in), .out_carry());

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Entered just after an edge; ends one idle edge later
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic sum_is(input logic [9:0] e, input string w);
    apb(1'b0, OFS_SUM, '0);
    check(w, rd[9:0], e);
  endtask : sum_is

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_bus;
    apb(1'b0, OFS_CTRL, '0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b1, 8'h18, 32'hffffffff);
    check("unmapped write err", err, 1'b1);
    apb(1'b0, 8'h18, '0);
    check("unmapped read", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, OFS_CTRL, 32'h00000201);
    apb(1'b0, OFS_CTRL, '0);
    check("ctrl readback", rd, 32'h00000201);
    $display("bus test done");
  endtask : t_bus

  task automatic t_add(input logic [9:0] a, b, input logic cin, lk, fr,
                       input logic [3:0] st);
    logic [10:0] s;
    logic [31:0] m;
    c = CTRL_RESET;
    c.mode = MODE_ARITH;
    c.chain_start = st;
    c.carry_in = cin;
    c.from_link = lk;
    c.bypass = 1'b1;
    c.fast_route = fr;
    wr_pair: apb(1'b1, OFS_OPERANDS, {6'h0, b, 6'h0, a});
    apb(1'b1, OFS_CTRL, 32'(c));
    s = ({1'b0, a} >> st) + ({1'b0, b} >> st) + (lk ? rc : cin);
    s = s << st;
    m = {15'h0, 1'b1, 6'h0, 10'h3ff << st};
    apb(1'b0, OFS_SUM, '0);
    check("sum", rd & m, {15'h0, s[10], 6'h0, s[9:0]} & m);
    check("carry cell", carry_out, s[10]);
    check("row link", out_carry, s[10]);
    check("local", loc & m[9:0], fr ? 10'h0 : s[9:0] & m[9:0]);
    check("fast", fast & m[9:0], fr ? s[9:0] & m[9:0] : 10'h0);
    $display("add test done");
  endtask : t_add

  task automatic t_reg;
    c = CTRL_RESET;
    c.mode = MODE_ARITH;
    c.clock_enable_first = 1'b1;
    apb(1'b1, OFS_OPERANDS, {6'h0, 10'h0f0, 6'h0, 10'h00f});
    apb(1'b1, OFS_CTRL, 32'(c));
    sum_is(10'h0ff, "registered");
    c.clock_enable_first = 1'b0;
    apb(1'b1, OFS_CTRL, 32'(c));
    apb(1'b1, OFS_OPERANDS, {6'h0, 10'h001, 6'h0, 10'h001});
    sum_is(10'h0ff, "held");
    apb(1'b1, OFS_ASYNC, 32'h2);
    sum_is(10'h3ff, "preset");
    apb(1'b1, OFS_ASYNC, 32'h3);
    sum_is(10'h000, "clear wins");
    apb(1'b1, OFS_ASYNC, 32'h0);
    c.clock_enable_first = 1'b1;
    c.chip_clear_enable = 1'b1;
    apb(1'b1, OFS_CTRL, 32'(c));
    sum_is(10'h002, "reload");
    clr_n <= 1'b0;
    repeat (4) @(posedge pclk);
    sum_is(10'h000, "chip clear");
    clr_n <= 1'b1;
    repeat (3) @(posedge pclk);
    sum_is(10'h002, "after chip clear");
    c.chip_clear_enable = 1'b0;
    apb(1'b1, OFS_CTRL, 32'(c));
    clr_n <= 1'b0;
    repeat (4) @(posedge pclk);
    sum_is(10'h002, "chip clear off");
    clr_n <= 1'b1;
    $display("register test done");
  endtask : t_reg

  task automatic t_mul;
    logic [15:0] ma[3] = '{16'hffff, 16'h8000, 16'h1234};
    logic [15:0] mb[3] = '{16'hffff, 16'h7fff, 16'h0003};
    logic [31:0] e;
    for (int k = 0; k < 12; k++) begin
      c = CTRL_RESET;
      c.mode = MODE_MULT;
      c.clock_enable_first = 1'b1;
      c.mult_signed = k[0];
      c.pipelined = k[1];
      apb(1'b1, OFS_MUL_OPS, {mb[k/4], ma[k/4]});
      apb(1'b1, OFS_CTRL, 32'(c));
      repeat (2) @(posedge pclk);
      if (k[0]) e = $signed(ma[k/4]) * $signed(mb[k/4]);
      else e = ma[k/4] * mb[k/4];
      apb(1'b0, OFS_PRODUCT, '0);
      check("product", rd, e);
      check("row quiet", row_out, '0);
    end
    c.clock_enable_first = 1'b0;
    apb(1'b1, OFS_CTRL, 32'(c));
    apb(1'b1, OFS_MUL_OPS, 32'h00020002);
    repeat (2) @(posedge pclk);
    apb(1'b0, OFS_PRODUCT, '0);
    check("product held", rd, e);
    apb(1'b1, OFS_ASYNC, 32'h2);
    c.clock_enable_first = 1'b1;
    apb(1'b1, OFS_CTRL, 32'(c));
    apb(1'b0, OFS_PRODUCT, '0);
    check("product preset", rd, 32'h0);
    sum_is(10'h002, "mult cell");
    apb(1'b1, OFS_ASYNC, 32'h0);
    apb(1'b0, OFS_PRODUCT, '0);
    check("product after preset", rd, 32'h4);
    $display("multiplier test done");
  endtask : t_mul

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus();
    t_add(10'h3ff, 10'h001, 1'b0, 1'b0, 1'b0, 4'd0);
    t_add(10'h208, 10'h208, 1'b0, 1'b0, 1'b0, 4'd0);
    t_add(10'h3ff, 10'h3ff, 1'b1, 1'b0, 1'b0, 4'd0);
    t_add(10'h155, 10'h2aa, 1'b1, 1'b0, 1'b1, 4'd0);
    t_add(10'h2f0, 10'h1f0, 1'b1, 1'b0, 1'b0, 4'd5);
    rc <= 1'b1;
    pick <= 1'b1;
    t_add(10'h0ff, 10'h100, 1'b0, 1'b1, 1'b0, 4'd0);
    pick <= 1'b0;
    t_add(10'h1ff, 10'h200, 1'b0, 1'b1, 1'b0, 4'd0);
    t_reg();
    t_mul();
    print_verdict();
  end
endmodule : carry_select_logic_cell_array_test

`default_nettype wire
